/* File: core/sleep_ctrl.sv */
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
// Summary of operation
// - Idle stops CPU and flash clocks, and the timer oscillator when timer 2 is async
// - Wake adds four halt cycles after startup
// - Noise mode stops I/O, CPU, flash clocks
// - Noise mode entry starts enabled ADC conversion
// - Noise mode wakes on listed events only
// - Power-down stops oscillator and generated clocks
// - Power-down wakes on reset, start, level, pinchange
// - Power-down wake waits fuse-selected startup delay
// - Power-save keeps timer 2 running
// - Timer 2 wake needs its mask and global enable
// - Running sync clock goes to timer 2 only
// - Standby keeps oscillator, wakes in six cycles
// - Deep modes accept only level interrupt zero
// - Stop bit freezes peripheral, blocks its registers
// - Clearing stop bit resumes frozen state
// - Bits 3 to 1 matter only active and idle; bit 0 in every mode
// - Upper four stop bits read zero
// - Bit 3 stops timer 1
// - Bit 2 stops serial port
// - Bit 1 stops uart
// - Bit 0 stops converter; comparator mux blocked
module sleep_ctrl #(
    parameter int STARTUP_CYCLES = 100
) (
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic CLK_EN,
    // Avalon-MM slave
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Core side
    input wire logic SLEEP_EXEC,
    input wire logic GLOBAL_INT_EN,
    input wire logic CRYSTAL_SELECTED,
    input wire logic ADC_ENABLED,
    input wire logic TIMER2_RUNNING,
    input wire logic TIMER2_ASYNC,
    input wire logic [1:0] TIMER2_INTERRUPT_MASK,
    // Wake events, synchronous to MCLK except the pins
    input wire logic EXT_INT0_LEVEL_PIN,
    input wire logic EXT_INT0_EDGE_IRQ,
    input wire logic PIN_CHANGE_PIN,
    input wire logic START_COND_IRQ,
    input wire logic TIMER2_OVF_IRQ,
    input wire logic TIMER2_CMP_IRQ,
    input wire logic ADC_DONE_IRQ,
    input wire logic NVM_READY_IRQ,
    input wire logic OTHER_IO_IRQ,
    input wire logic RESET_WAKE,
    // Clock enables and status
    output logic CPU_CLK_EN,
    output logic FLASH_CLK_EN,
    output logic IO_CLK_EN,
    output logic ADC_CLK_EN,
    output logic ASY_CLK_EN,
    output logic MAIN_OSC_EN,
    output logic TIMER_OSC_EN,
    output logic TIMER2_SYNC_CLK_EN,
    output logic TIMER1_CLK_EN,
    output logic SPI_CLK_EN,
    output logic UART_CLK_EN,
    output logic ADC_PERIPH_CLK_EN,
    output logic COMPARATOR_MUX_ALLOWED,
    output logic ADC_START,
    output logic SLEEPING
);

    localparam int HALT_W = 16;
    localparam logic [HALT_W-1:0] HALT4 = HALT_W'(sleep_pkg::WAKE_HALT_CYCLES);
    localparam logic [HALT_W-1:0] STANDBY_W = HALT_W'(sleep_pkg::STANDBY_WAKE_CYCLES);

    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_SLEEP = 4'h2,
        ST_STARTUP = 4'h4,
        ST_HALT = 4'h8
    } state_type;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: first stage read only by the second
    logic [1:0] lvl_s1_r, lvl_s2_r;
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            lvl_s1_r <= 2'h0;
            lvl_s2_r <= 2'h0;
        end else if (CLK_EN) begin
            lvl_s1_r <= {PIN_CHANGE_PIN, EXT_INT0_LEVEL_PIN};
            lvl_s2_r <= lvl_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic sleep_en_r;
    logic [2:0] mode_r;
    logic [3:0] stop_r;
    state_type state_r;
    logic [2:0] active_mode_r;
    logic [HALT_W-1:0] cnt_r;

    // Bus answers in the cycle after the request is seen: one wait cycle
    logic ack_r;
    wire req = (AVS_READ || AVS_WRITE) && !ack_r;
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            ack_r <= 1'b0;
        end else if (CLK_EN) begin
            ack_r <= req;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            AVS_WAITREQUEST <= 1'b1;
        end else if (CLK_EN) begin
            AVS_WAITREQUEST <= !req;
        end
    end

    // Control register writes take effect at the accepting edge
    wire wr = AVS_WRITE && ack_r;
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            sleep_en_r <= sleep_pkg::SLEEP_CTRL_RESET[sleep_pkg::ENABLE_BIT];
            mode_r <= sleep_pkg::SLEEP_CTRL_RESET[3:1];
        end else if (CLK_EN && wr && AVS_ADDRESS == sleep_pkg::SLEEP_CTRL_OFS) begin
            sleep_en_r <= AVS_WRITEDATA[sleep_pkg::ENABLE_BIT];
            mode_r <= AVS_WRITEDATA[sleep_pkg::SM_LSB +: 3];
        end
    end

    // Only four bits exist; upper bits are never stored
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            stop_r <= sleep_pkg::CLK_STOP_RESET;
        end else if (CLK_EN && wr && AVS_ADDRESS == sleep_pkg::CLK_STOP_OFS) begin
            stop_r <= AVS_WRITEDATA[3:0];
        end
    end

    // Read mux; unmapped addresses read zero
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            AVS_READDATA <= 32'h0;
        end else if (CLK_EN) begin
            case (AVS_ADDRESS)
                sleep_pkg::SLEEP_CTRL_OFS: AVS_READDATA <= {28'h0, mode_r, sleep_en_r};
                sleep_pkg::CLK_STOP_OFS: AVS_READDATA <= {28'h0, stop_r};
                sleep_pkg::STATUS_OFS: AVS_READDATA <= {24'h0, active_mode_r, 1'b0, state_r};
                default: AVS_READDATA <= 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode helpers
    function automatic logic mode_valid(input logic [2:0] m, input logic xtal);
        case (m)
            sleep_pkg::MODE_IDLE, sleep_pkg::MODE_NOISE,
            sleep_pkg::MODE_PDOWN, sleep_pkg::MODE_PSAVE: mode_valid = 1'b1;
            sleep_pkg::MODE_STANDBY: mode_valid = xtal;
            default: mode_valid = 1'b0;
        endcase
    endfunction

    // Qualified wake sources per mode
    function automatic logic wake_ok(input logic [2:0] m);
        logic lvl0;
        logic t2;
        lvl0 = lvl_s2_r[0] || lvl_s2_r[1] || START_COND_IRQ || RESET_WAKE;
        t2 = GLOBAL_INT_EN && ((TIMER2_OVF_IRQ && TIMER2_INTERRUPT_MASK[0])
            || (TIMER2_CMP_IRQ && TIMER2_INTERRUPT_MASK[1]));
        case (m)
            sleep_pkg::MODE_IDLE: wake_ok = lvl0 || EXT_INT0_EDGE_IRQ || t2
                || ADC_DONE_IRQ || NVM_READY_IRQ || OTHER_IO_IRQ;
            sleep_pkg::MODE_NOISE: wake_ok = lvl0 || ADC_DONE_IRQ || NVM_READY_IRQ
                || (t2 && !TIMER2_ASYNC);
            sleep_pkg::MODE_PSAVE: wake_ok = lvl0 || t2;
            default: wake_ok = lvl0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Sleep sequencer
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            state_r <= ST_RUN;
            active_mode_r <= sleep_pkg::MODE_IDLE;
            cnt_r <= '0;
        end else if (CLK_EN) begin
            case (state_r)
                ST_RUN: begin
                    if (SLEEP_EXEC && sleep_en_r && mode_valid(mode_r, CRYSTAL_SELECTED)) begin
                        state_r <= ST_SLEEP;
                        active_mode_r <= mode_r;
                    end
                end
                ST_SLEEP: begin
                    if (wake_ok(active_mode_r)) begin
                        state_r <= (active_mode_r[2:1] == 2'h0) ? ST_HALT : ST_STARTUP;
                        case (active_mode_r)
                            sleep_pkg::MODE_PDOWN, sleep_pkg::MODE_PSAVE:
                                cnt_r <= HALT_W'(STARTUP_CYCLES);
                            sleep_pkg::MODE_STANDBY: cnt_r <= STANDBY_W - HALT4;
                            default: cnt_r <= HALT4 - 1'b1;
                        endcase
                    end
                end
                ST_STARTUP: begin
                    if (cnt_r < HALT_W'(2)) begin
                        state_r <= ST_HALT;
                        cnt_r <= HALT4 - 1'b1;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                ST_HALT: begin
                    if (cnt_r == '0) begin
                        state_r <= ST_RUN;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                default: state_r <= ST_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock enables registered from the current state, one cycle behind it
    logic asleep;
    logic [2:0] m;
    assign asleep = (state_r != ST_RUN);
    assign m = active_mode_r;

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            CPU_CLK_EN <= 1'b1;
            FLASH_CLK_EN <= 1'b1;
            IO_CLK_EN <= 1'b1;
            ADC_CLK_EN <= 1'b1;
            ASY_CLK_EN <= 1'b1;
            MAIN_OSC_EN <= 1'b1;
            TIMER_OSC_EN <= 1'b1;
            TIMER2_SYNC_CLK_EN <= 1'b1;
            SLEEPING <= 1'b0;
        end else if (CLK_EN) begin
            SLEEPING <= asleep;
            CPU_CLK_EN <= !asleep;
            FLASH_CLK_EN <= !asleep;
            IO_CLK_EN <= !asleep || m == sleep_pkg::MODE_IDLE;
            ADC_CLK_EN <= !asleep || m == sleep_pkg::MODE_IDLE || m == sleep_pkg::MODE_NOISE;
            ASY_CLK_EN <= !asleep || m == sleep_pkg::MODE_IDLE || m == sleep_pkg::MODE_NOISE
                || m == sleep_pkg::MODE_PSAVE;
            MAIN_OSC_EN <= !asleep || m == sleep_pkg::MODE_IDLE || m == sleep_pkg::MODE_NOISE
                || m == sleep_pkg::MODE_STANDBY || state_r != ST_SLEEP;
            TIMER_OSC_EN <= !asleep || ((m == sleep_pkg::MODE_IDLE
                || m == sleep_pkg::MODE_NOISE) && !TIMER2_ASYNC) || m == sleep_pkg::MODE_PSAVE;
            // Sync clock in power-save feeds timer 2 only
            TIMER2_SYNC_CLK_EN <= !asleep || m == sleep_pkg::MODE_IDLE
                || m == sleep_pkg::MODE_NOISE
                || (m == sleep_pkg::MODE_PSAVE && TIMER2_RUNNING && !TIMER2_ASYNC);
        end
    end

    // Peripheral gates follow the I/O or ADC clock and the stop bits
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            TIMER1_CLK_EN <= 1'b1;
            SPI_CLK_EN <= 1'b1;
            UART_CLK_EN <= 1'b1;
            ADC_PERIPH_CLK_EN <= 1'b1;
            COMPARATOR_MUX_ALLOWED <= 1'b1;
        end else if (CLK_EN) begin
            TIMER1_CLK_EN <= IO_CLK_EN && !stop_r[sleep_pkg::TIMER1_STOP_BIT];
            SPI_CLK_EN <= IO_CLK_EN && !stop_r[sleep_pkg::SPI_STOP_BIT];
            UART_CLK_EN <= IO_CLK_EN && !stop_r[sleep_pkg::UART_STOP_BIT];
            ADC_PERIPH_CLK_EN <= ADC_CLK_EN && !stop_r[sleep_pkg::ADC_STOP_BIT];
            COMPARATOR_MUX_ALLOWED <= !stop_r[sleep_pkg::ADC_STOP_BIT];
        end
    end

    // One-cycle conversion start on entering noise reduction
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            ADC_START <= 1'b0;
        end else if (CLK_EN) begin
            ADC_START <= state_r == ST_RUN && SLEEP_EXEC && sleep_en_r
                && mode_r == sleep_pkg::MODE_NOISE && ADC_ENABLED
                && !stop_r[sleep_pkg::ADC_STOP_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_wake_halt;
        state_r == ST_HALT [*4] ##1 state_r == ST_RUN;
    endsequence

    property p_halt4;
        @(posedge MCLK) disable iff (!RESETN || !CLK_EN)
        $rose(state_r == ST_HALT) |-> s_wake_halt;
    endproperty
    a_halt4: assert property (p_halt4) else $error("wake halt not four cycles");

    property p_cpu_off;
        @(posedge MCLK) disable iff (!RESETN || !CLK_EN)
        (state_r == ST_SLEEP) |=> !CPU_CLK_EN && !FLASH_CLK_EN;
    endproperty
    a_cpu_off: assert property (p_cpu_off) else $error("cpu clock on in sleep");

    property p_noise_io;
        @(posedge MCLK) disable iff (!RESETN || !CLK_EN)
        (state_r == ST_SLEEP && m == sleep_pkg::MODE_NOISE) |=> !IO_CLK_EN && ADC_CLK_EN;
    endproperty
    a_noise_io: assert property (p_noise_io) else $error("noise mode clocks wrong");

    property p_pdown_osc;
        @(posedge MCLK) disable iff (!RESETN || !CLK_EN)
        (state_r == ST_SLEEP && m == sleep_pkg::MODE_PDOWN) |=> !MAIN_OSC_EN && !ASY_CLK_EN;
    endproperty
    a_pdown_osc: assert property (p_pdown_osc) else $error("power-down osc on");

    property p_reserved;
        @(posedge MCLK) disable iff (!RESETN || !CLK_EN)
        (state_r == ST_RUN && mode_r[2] && mode_r != sleep_pkg::MODE_STANDBY)
            |=> state_r == ST_RUN;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved mode slept");

    property p_edge_ignored;
        @(posedge MCLK) disable iff (!RESETN || !CLK_EN)
        (state_r == ST_SLEEP && m == sleep_pkg::MODE_PDOWN && !RESET_WAKE && !START_COND_IRQ
            && !lvl_s2_r[0] && !lvl_s2_r[1]) |=> state_r == ST_SLEEP;
    endproperty
    a_edge_ignored: assert property (p_edge_ignored) else $error("bad wake");

    property p_stop_gate;
        @(posedge MCLK) disable iff (!RESETN || !CLK_EN)
        stop_r[sleep_pkg::TIMER1_STOP_BIT] |=> !TIMER1_CLK_EN;
    endproperty
    a_stop_gate: assert property (p_stop_gate) else $error("timer 1 not stopped");

    property p_upper_zero;
        @(posedge MCLK) disable iff (!RESETN || !CLK_EN)
        (AVS_READ && ack_r && AVS_ADDRESS == sleep_pkg::CLK_STOP_OFS) |-> AVS_READDATA[31:4] == 0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("reserved bits set");

    sequence s_standby_wake;
        (state_r != ST_RUN) [*6] ##1 state_r == ST_RUN;
    endsequence

    property p_standby_wake;
        @(posedge MCLK) disable iff (!RESETN || !CLK_EN)
        ($rose(state_r == ST_STARTUP) && m == sleep_pkg::MODE_STANDBY) |-> s_standby_wake;
    endproperty
    a_standby_wake: assert property (p_standby_wake) else $error("standby wake not 6");

endmodule

/* File: core/sleep_pkg.sv */
package sleep_pkg;
    // Sleep mode codes
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_NOISE = 3'h1;
    localparam logic [2:0] MODE_PDOWN = 3'h2;
    localparam logic [2:0] MODE_PSAVE = 3'h3;
    localparam logic [2:0] MODE_STANDBY = 3'h6;
    // Register byte addresses (word aligned)
    localparam logic [3:0] SLEEP_CTRL_OFS = 4'h0;
    localparam logic [3:0] CLK_STOP_OFS = 4'h4;
    localparam logic [3:0] STATUS_OFS = 4'h8;
    // Field positions
    localparam int ENABLE_BIT = 0;
    localparam int SM_LSB = 1;
    localparam int TIMER1_STOP_BIT = 3;
    localparam int SPI_STOP_BIT = 2;
    localparam int UART_STOP_BIT = 1;
    localparam int ADC_STOP_BIT = 0;
    // Reset values
    localparam logic [3:0] SLEEP_CTRL_RESET = 4'h0;
    localparam logic [3:0] CLK_STOP_RESET = 4'h0;
    // Timing
    localparam int WAKE_HALT_CYCLES = 4;
    localparam int STANDBY_WAKE_CYCLES = 6;
    localparam int CLK_PERIOD_NS = 10;
    localparam int PDOWN_STARTUP_NS_DEFAULT = 1000;
endpackage

/* File: testbench/sleep_partner.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////
// Core-side model: issues the sleep pulse and holds wake events
module sleep_partner (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [9:0] wake_sel,
    input wire logic sleeping,
    output logic sleep_exec,
    output logic [9:0] wake
);
    // Sleep pulse only when asked; the bench always writes mode and enable first, once with the enable cleared
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) sleep_exec <= 1'b0;
        else sleep_exec <= go;
    end
    // Events stay up while asleep so a level wake is never missed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) wake <= 10'h000;
        else wake <= wake_sel & {10{sleeping}};
    end
endmodule

/* File: testbench/sleep_mode_clock_gating_bench.sv */
`timescale 1ns/10ps
module sleep_mode_clock_gating_bench;
    localparam int SU = 3;
    logic clk, rst_n, go, sx, gie, xtal, adc_en, t2a, rd, wr, wreq, slp, adc_st, cmp, t2s;
    logic t2r, tos;
    logic [3:0] addr, per;
    logic [1:0] mask;
    logic [9:0] wsel, wk;
    logic [31:0] wdat, rdat, q, v;
    logic [5:0] dom;
    int error_cnt = 0;
    int checks_done = 0;
    int m, n, lat;
    bit ok, st_seen;
    int md[5] = '{0, 1, 2, 3, 6};
    int nm[5] = '{4, 5, 7, 6, 2};

    ////////////////////////////////////////////////////////////////////////
    sleep_ctrl #(.STARTUP_CYCLES(SU)) sleep_ctrl_inst (
        .MCLK(clk), .RESETN(rst_n), .CLK_EN(1'b1), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
        .SLEEP_EXEC(sx), .GLOBAL_INT_EN(gie), .CRYSTAL_SELECTED(xtal), .ADC_ENABLED(adc_en),
        .TIMER2_RUNNING(t2r), .TIMER2_ASYNC(t2a), .TIMER2_INTERRUPT_MASK(mask),
        .EXT_INT0_LEVEL_PIN(wk[0]), .EXT_INT0_EDGE_IRQ(wk[1]), .PIN_CHANGE_PIN(wk[2]),
        .START_COND_IRQ(wk[3]), .TIMER2_OVF_IRQ(wk[4]), .TIMER2_CMP_IRQ(wk[5]),
        .ADC_DONE_IRQ(wk[6]), .NVM_READY_IRQ(wk[7]), .OTHER_IO_IRQ(wk[8]),
        .RESET_WAKE(wk[9]), .CPU_CLK_EN(dom[5]), .FLASH_CLK_EN(dom[4]), .IO_CLK_EN(dom[3]),
        .ADC_CLK_EN(dom[2]), .ASY_CLK_EN(dom[1]), .MAIN_OSC_EN(dom[0]), .TIMER_OSC_EN(tos),
        .TIMER2_SYNC_CLK_EN(t2s), .TIMER1_CLK_EN(per[3]), .SPI_CLK_EN(per[2]),
        .UART_CLK_EN(per[1]), .ADC_PERIPH_CLK_EN(per[0]), .COMPARATOR_MUX_ALLOWED(cmp),
        .ADC_START(adc_st), .SLEEPING(slp));
    sleep_partner sleep_partner_inst (.clk(clk), .rst_n(rst_n), .go(go), .wake_sel(wsel),
        .sleeping(slp), .sleep_exec(sx), .wake(wk));

    ////////////////////////////////////////////////////////////////////////
    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Catch the one-cycle conversion start whenever it comes
    always @(posedge clk) if (adc_st === 1'b1) st_seen = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Model: running domains {cpu, flash, io, adc, async, main osc}
    function automatic logic [5:0] exp_dom(input int md_i);
        case (md_i)
            0: return 6'h0F;
            1: return 6'h07;
            3: return 6'h02;
            6: return 6'h01;
            default: return 6'h00;
        endcase
    endfunction
    // Model: event i wakes mode md_i; timer 2 also needs its mask and global enable
    function automatic bit may_wake(input int md_i, input int i, input logic g,
                                    input logic [1:0] k);
        case (i)
            0, 2, 3, 9: return 1'b1;
            1, 8: return md_i == 0;
            4, 5: return g && k[i-4] && md_i != 2 && md_i != 6;
            default: return md_i < 2;
        endcase
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (error_cnt == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // One Avalon transfer, held until waitrequest is seen low
    // Only the watchdog ends a wait that never gets its answer
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (wreq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // Program mode and enable, read back, then execute sleep
    task automatic nap(input int md_i, input logic en);
        bus(1'b1, sleep_pkg::SLEEP_CTRL_OFS, {28'h0, md_i[2:0], en});
        bus(1'b0, sleep_pkg::SLEEP_CTRL_OFS, 32'h0);
        check(q, {28'h0, md_i[2:0], en});
        st_seen = 1'b0;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (5) @(posedge clk);
    endtask
    // Bounded wait for the cpu clock to come back
    task automatic wait_run();
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (dom[5] !== 1'b1 && n < 16);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog: the whole run needs a few thousand cycles
    initial begin
        #200000;
        error_cnt++;
        print_verdict();
    end
    // Main sequence
    initial begin
        {rst_n, go, gie, adc_en, t2a, t2r, rd, wr} <= 8'h00;
        {addr, mask, wsel, wdat, xtal} <= {4'h0, 2'h0, 10'h000, 32'h0, 1'b1};
        v = $urandom(32'hAD26AB9D);
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, sleep_pkg::CLK_STOP_OFS, 32'h0);
        check(q, {28'h0, sleep_pkg::CLK_STOP_RESET});
        bus(1'b1, 4'hC, 32'hFFFF_FFFF);
        bus(1'b0, 4'hC, 32'h0);
        check(q, 32'h0);
        repeat (6) begin
            v = $urandom;
            bus(1'b1, sleep_pkg::CLK_STOP_OFS, v);
            bus(1'b0, sleep_pkg::CLK_STOP_OFS, 32'h0);
            check(q, {28'h0, v[3:0]});
            repeat (3) @(posedge clk);
            check(per, 4'(~v[3:0]));
            check(cmp, !v[0]);
        end
        // Reserved codes, standby without crystal, cleared enable: all six domain clocks keep running
        for (int k = 0; k < 5; k++) begin
            xtal <= (k != 3);
            nap(nm[k], k != 4);
            check({slp, dom}, 7'h3F);
        end
        xtal <= 1'b1;
        // Every mode against every wake event
        for (int k = 0; k < 5; k++) begin
            for (int i = 0; i < 10; i++) begin
                m = md[k];
                v = $urandom;
                gie <= v[4];
                mask <= v[6:5];
                t2a <= (m == 3) & v[7];
                t2r <= v[9];
                adc_en <= v[8] & !v[0];
                bus(1'b1, sleep_pkg::CLK_STOP_OFS, v);
                nap(m, 1'b1);
                check({slp, dom}, {1'b1, exp_dom(m)});
                check(tos, m < 2 || m == 3);
                if (m >= 2) check({t2s, per}, {m == 3 && !t2a && t2r, 4'h0});
                else if (m == 0) check(per, 4'(~v[3:0]));
                if (m != 0) check(st_seen, m == 1 && adc_en);
                ok = may_wake(m, i, gie, mask);
                // Restart wait and halt, plus event, capture, gate and sampling edges
                lat = (m == 2 || m == 3) ? SU + sleep_pkg::WAKE_HALT_CYCLES
                    : (m == 6 ? sleep_pkg::STANDBY_WAKE_CYCLES : sleep_pkg::WAKE_HALT_CYCLES);
                lat = lat + 4 + ((i == 0 || i == 2) ? 2 : 0);
                wsel <= 10'h001 << i;
                wait_run();
                if (ok) check(n, lat);
                else begin
                    check(dom[5], 1'b0);
                    wsel <= 10'h200;
                    wait_run();
                    check(dom[5], 1'b1);
                end
                wsel <= 10'h000;
                repeat (4) @(posedge clk);
            end
        end
        print_verdict();
    end
endmodule
